// [rtl/ivm_cfg.svh]
// interrupt vector map constants: table offsets, vector numbers, sizes
`ifndef IVM_CFG_SVH
`define IVM_CFG_SVH
`define IVM_VEC_W 7
`define IVM_OFS_W 10
`define IVM_NUM_VEC 81
`define IVM_TABLE_TOP 10'h3FC
`define IVM_VEC_CALLV0 7'h00
`define IVM_VEC_RESET 7'h08
`define IVM_VEC_SOFT_TRAP 7'h09
`define IVM_VEC_UNDEF 7'h0A
`define IVM_VEC_NMI 7'h0B
`define IVM_VEC_DELAYED 7'h0C
`define IVM_VEC_RC_TICK 7'h0D
`define IVM_VEC_MC_TICK 7'h0E
`define IVM_VEC_SC_TICK 7'h0F
`define IVM_VEC_LOW_VOLT 7'h10
`define IVM_VEC_CAN 7'h23
`define IVM_FIRST_ICR_VEC 7'h0C
`endif

// [rtl/ivm_pkg.sv]
// interrupt vector map types
package ivm_pkg;
  typedef enum logic [1:0] {
    IVM_IDLE = 2'b00,
    IVM_PRESENT = 2'b01,
    IVM_DMA_WAIT = 2'b10
  } ivm_state_t;
  typedef struct packed {
    logic valid;
    logic dma_ok;
    logic has_icr;
  } ivm_attr_t;
endpackage

// [rtl/ivm_attr_rom.sv]
// registered attribute lookup: valid, dma-clearable and priority-index flags per vector
`timescale 1ns/100ps
`include "ivm_cfg.svh"
module ivm_attr_rom
  import ivm_pkg::*;
#(
  parameter int VEC_W = `IVM_VEC_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // lookup
  input wire logic [VEC_W-1:0] vec,
  output ivm_attr_t attr_q
);
  // *********************************
  // vector attribute table
  // *********************************
  function automatic ivm_attr_t lookup(input logic [VEC_W-1:0] v);
    ivm_attr_t a;
    int n;
    n = int'(v);
    a = '{valid: 1'b0, dma_ok: 1'b0, has_icr: 1'b0};
    case (n)
      17, 19, 20, 21, 24, 25, 26, 27, 28, 29, 30,
      38, 39, 41, 42, 44, 45, 50, 52, 59, 61, 64,
      65, 66, 69, 70, 71, 74, 75, 77, 78: begin
        a = '{valid: 1'b1, dma_ok: 1'b1, has_icr: 1'b1};
      end
      12, 13, 14, 15, 16, 35: begin
        a = '{valid: 1'b1, dma_ok: 1'b0, has_icr: 1'b1};
      end
      0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11: begin
        a = '{valid: 1'b1, dma_ok: 1'b0, has_icr: 1'b0};
      end
      default: begin
        a = '{valid: 1'b0, dma_ok: 1'b0, has_icr: 1'b0};
      end
    endcase
    return a;
  endfunction

  // registered read port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      attr_q <= '{valid: 1'b0, dma_ok: 1'b0, has_icr: 1'b0};
    end else begin
      attr_q <= lookup(vec);
    end
  end
endmodule

// [rtl/ivm_top.sv]
// interrupt vector map: selects the pending source, forms table offset, routes dma clears
// *********************************
// *********************************
`timescale 1ns/100ps
`include "ivm_cfg.svh"
module ivm_top
  import ivm_pkg::*;
#(
  parameter int VEC_W = `IVM_VEC_W,
  parameter int OFS_W = `IVM_OFS_W,
  parameter int NUM_VEC = `IVM_NUM_VEC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // core-side exception and instruction sources
  input wire logic call_vector_instruction,
  input wire logic [2:0] call_vector_sel,
  input wire logic soft_trap_instruction,
  input wire logic undefined_instruction,
  input wire logic nmi_request,
  // peripheral request levels, one bit per vector number
  input wire logic [NUM_VEC-1:0] periph_request,
  // dma channel: route flag and completion pulse
  input wire logic [NUM_VEC-1:0] dma_route_en,
  input wire logic dma_done,
  // processor vector fetch handshake
  input wire logic fetch_ack,
  output logic vec_valid_q,
  output logic [VEC_W-1:0] vec_num_q,
  output logic [OFS_W-1:0] vec_offset_q,
  output logic vec_has_icr_q,
  output logic [VEC_W-1:0] icr_index_q,
  // dma request and clear back to the source
  output logic dma_req_q,
  output logic [VEC_W-1:0] dma_vec_q,
  output logic [NUM_VEC-1:0] src_clear_q
);
  // *********************************
  // source selection
  // *********************************
  ivm_state_t state_q;
  ivm_attr_t attr_q;
  logic [VEC_W-1:0] pick_d;
  logic [VEC_W-1:0] pick_q;
  logic pick_any_d;
  logic [NUM_VEC-1:0] masked_req;
  logic [NUM_VEC-1:0] allowed;
  logic held_q;
  logic settle_q;

  // hardware cannot raise reserved or core-only vectors from the peripheral bus
  genvar gi;
  generate
    for (gi = 0; gi < NUM_VEC; gi++) begin : g_allow
      assign allowed[gi] = (gi >= int'(`IVM_VEC_DELAYED)) && (gi != 18) && (gi != 22) && (gi != 23)
        && !(gi >= 31 && gi <= 34) && (gi != 36) && (gi != 37) && (gi != 40) && (gi != 43)
        && !(gi >= 46 && gi <= 49) && (gi != 51) && !(gi >= 53 && gi <= 58) && (gi != 60)
        && (gi != 62) && (gi != 63) && (gi != 67) && (gi != 68) && (gi != 72) && (gi != 73)
        && (gi != 76) && (gi != 79) && (gi != 80);
      assign masked_req[gi] = periph_request[gi] & allowed[gi];
    end
  endgenerate

  // fixed order: core events first, then lowest peripheral vector number
  always_comb begin
    pick_d = '0;
    pick_any_d = 1'b1;
    if (nmi_request) begin
      pick_d = `IVM_VEC_NMI;
    end else if (undefined_instruction) begin
      pick_d = `IVM_VEC_UNDEF;
    end else if (soft_trap_instruction) begin
      pick_d = `IVM_VEC_SOFT_TRAP;
    end else if (call_vector_instruction) begin
      pick_d = `IVM_VEC_CALLV0 + {4'h0, call_vector_sel};
    end else begin
      pick_any_d = 1'b0;
      for (int i = NUM_VEC - 1; i >= 0; i--) begin
        if (masked_req[i]) begin
          pick_d = VEC_W'(i);
          pick_any_d = 1'b1;
        end
      end
    end
  end

  // candidate register feeding the attribute lookup
  // frozen from latch to decision so vector and attributes stay paired
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pick_q <= `IVM_VEC_RESET;
      held_q <= 1'b1;
    end else if (state_q == IVM_IDLE && !held_q) begin
      pick_q <= pick_d;
      held_q <= pick_any_d;
    end else if (state_q == IVM_IDLE && settle_q) begin
      held_q <= 1'b0; // decision taken, sample afresh
    end
  end

  ivm_attr_rom #(
    .VEC_W(VEC_W)
  ) u_rom (
    .ref_clk(ref_clk),
    .rst(rst),
    .vec(pick_q),
    .attr_q(attr_q)
  );

  // *********************************
  // presentation state machine
  // *********************************
  // one-cycle settle strobe once the lookup has caught up
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      settle_q <= 1'b0;
    end else begin
      settle_q <= (state_q == IVM_IDLE) && held_q && !settle_q;
    end
  end

  logic route_dma;
  assign route_dma = attr_q.dma_ok && dma_route_en[pick_q];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= IVM_IDLE;
    end else begin
      case (state_q)
        IVM_IDLE: begin
          if (settle_q && attr_q.valid) begin
            state_q <= route_dma ? IVM_DMA_WAIT : IVM_PRESENT;
          end
        end
        IVM_PRESENT: begin
          if (fetch_ack) begin
            state_q <= IVM_IDLE;
          end
        end
        IVM_DMA_WAIT: begin
          if (dma_done) begin
            state_q <= IVM_IDLE;
          end
        end
        default: begin
          state_q <= IVM_IDLE;
        end
      endcase
    end
  end

  // vector outputs toward the processor
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vec_valid_q <= 1'b0;
      vec_num_q <= '0;
      vec_offset_q <= '0;
      vec_has_icr_q <= 1'b0;
      icr_index_q <= '0;
    end else if (state_q == IVM_IDLE && settle_q && attr_q.valid && !route_dma) begin
      vec_valid_q <= 1'b1;
      vec_num_q <= pick_q;
      vec_offset_q <= `IVM_TABLE_TOP - OFS_W'({pick_q, 2'b00});
      vec_has_icr_q <= attr_q.has_icr;
      icr_index_q <= attr_q.has_icr ? pick_q : '0;
    end else if (state_q == IVM_PRESENT && fetch_ack) begin
      vec_valid_q <= 1'b0;
    end
  end

  // dma request and source clear on completion
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dma_req_q <= 1'b0;
      dma_vec_q <= '0;
      src_clear_q <= '0;
    end else begin
      src_clear_q <= '0;
      if (state_q == IVM_IDLE && settle_q && attr_q.valid && route_dma) begin
        dma_req_q <= 1'b1;
        dma_vec_q <= pick_q;
      end else if (state_q == IVM_DMA_WAIT && dma_done) begin
        dma_req_q <= 1'b0;
        src_clear_q[dma_vec_q] <= 1'b1;
      end
    end
  end

  // *********************************
  // checks
  // *********************************
  property p_offset_formula;
    @(posedge ref_clk) disable iff (rst)
      $rose(vec_valid_q) |-> vec_offset_q == (`IVM_TABLE_TOP - OFS_W'({vec_num_q, 2'b00}));
  endproperty
  a_offset_formula: assert property (p_offset_formula) else $error("offset mismatch");

  property p_no_dma_core;
    @(posedge ref_clk) disable iff (rst)
      dma_req_q |-> (dma_vec_q > `IVM_VEC_LOW_VOLT) && (dma_vec_q != `IVM_VEC_CAN);
  endproperty
  a_no_dma_core: assert property (p_no_dma_core) else $error("dma on non-clearable vector");

  property p_icr_equal;
    @(posedge ref_clk) disable iff (rst)
      (vec_valid_q && vec_has_icr_q) |-> icr_index_q == vec_num_q && vec_num_q >= `IVM_FIRST_ICR_VEC;
  endproperty
  a_icr_equal: assert property (p_icr_equal) else $error("priority index mismatch");

  property p_no_icr_low;
    @(posedge ref_clk) disable iff (rst)
      (vec_valid_q && vec_num_q < `IVM_FIRST_ICR_VEC) |-> !vec_has_icr_q;
  endproperty
  a_no_icr_low: assert property (p_no_icr_low) else $error("core vector has index");

  // clear pulse on the served bit, then gone again
  sequence s_clear_pulse;
    src_clear_q[dma_vec_q] && !dma_req_q;
  endsequence

  sequence s_clear_gone;
    src_clear_q == '0;
  endsequence

  property p_clear_after_done;
    @(posedge ref_clk) disable iff (rst)
      (dma_req_q && dma_done) |=> s_clear_pulse ##1 s_clear_gone;
  endproperty
  a_clear_after_done: assert property (p_clear_after_done) else $error("dma clear missing");

  // presented vector stands unchanged until the processor takes it
  property p_present_hold;
    @(posedge ref_clk) disable iff (rst)
      (vec_valid_q && !fetch_ack) |=> vec_valid_q && $stable(vec_num_q) && $stable(vec_offset_q);
  endproperty
  a_present_hold: assert property (p_present_hold) else $error("vector dropped early");

  // dma request stands unchanged until the transfer completes
  property p_dma_hold;
    @(posedge ref_clk) disable iff (rst)
      (dma_req_q && !dma_done) |=> dma_req_q && $stable(dma_vec_q);
  endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("dma request dropped early");
endmodule

// [verification/ivm_core_model.sv]
// processor and dma partner: answers presented vectors and dma requests after a lag
`timescale 1ns/100ps
module ivm_core_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // answer lag in cycles, 0 is prompt
  input wire logic [1:0] lag,
  // design outputs watched
  input wire logic vec_valid_q,
  input wire logic dma_req_q,
  // one-cycle handshake pulses back
  output logic fetch_ack,
  output logic dma_done
);
  logic [1:0] wait_q;

  // count the lag, then pulse ack or done once
  always_ff @(posedge ref_clk) begin
    if (rst || fetch_ack || dma_done) begin
      fetch_ack <= 1'b0;
      dma_done <= 1'b0;
      wait_q <= 2'h0;
    end else if ((vec_valid_q || dma_req_q) && wait_q >= lag) begin
      fetch_ack <= vec_valid_q;
      dma_done <= dma_req_q;
    end else if (vec_valid_q || dma_req_q) begin
      wait_q <= wait_q + 2'h1; // lag may change between requests
    end
  end
endmodule

// [verification/interrupt_vector_map_test.sv]
// testbench for the interrupt vector map: reset vector, core sources, full vector table
`timescale 1ns/100ps
`include "ivm_cfg.svh"
module interrupt_vector_map_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic call_vector_instruction = 1'b0;
  logic [2:0] call_vector_sel = 3'h0;
  logic soft_trap_instruction = 1'b0;
  logic undefined_instruction = 1'b0;
  logic nmi_request = 1'b0;
  logic [`IVM_NUM_VEC-1:0] periph_request = '0;
  logic [`IVM_NUM_VEC-1:0] dma_route_en = '0;
  logic [1:0] lag = 2'h0;
  logic fetch_ack, dma_done, vec_valid_q, vec_has_icr_q, dma_req_q;
  logic [`IVM_VEC_W-1:0] vec_num_q, icr_index_q, dma_vec_q;
  logic [`IVM_OFS_W-1:0] vec_offset_q;
  logic [`IVM_NUM_VEC-1:0] src_clear_q, val_m, dma_m;
  int mismatches = 0;
  int n_checks = 0;
  // dma-clearable vector numbers
  int dl[31] = '{17, 19, 20, 21, 24, 25, 26, 27, 28, 29, 30, 38, 39, 41, 42, 44, 45, 50, 52,
                 59, 61, 64, 65, 66, 69, 70, 71, 74, 75, 77, 78};

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  ivm_top i_dut (.ref_clk(ref_clk), .rst(rst), .call_vector_instruction(call_vector_instruction),
    .call_vector_sel(call_vector_sel), .soft_trap_instruction(soft_trap_instruction),
    .undefined_instruction(undefined_instruction), .nmi_request(nmi_request),
    .periph_request(periph_request), .dma_route_en(dma_route_en), .dma_done(dma_done),
    .fetch_ack(fetch_ack), .vec_valid_q(vec_valid_q), .vec_num_q(vec_num_q),
    .vec_offset_q(vec_offset_q), .vec_has_icr_q(vec_has_icr_q), .icr_index_q(icr_index_q),
    .dma_req_q(dma_req_q), .dma_vec_q(dma_vec_q), .src_clear_q(src_clear_q));

  ivm_core_model i_core (.ref_clk(ref_clk), .rst(rst), .lag(lag), .vec_valid_q(vec_valid_q),
    .dma_req_q(dma_req_q), .fetch_ack(fetch_ack), .dma_done(dma_done));

  // *********************************
  // checking and closing
  // *********************************
  task automatic chk(input logic [80:0] seen, input logic [80:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // raise one source (0 call_vector_instruction, 1 trap, 2 undef, 3 nmi, 4 peripheral, 5 none), judge the answer
  task automatic go(input int n, input int src);
    int k;
    logic dm;
    dm = (src == 4) && dma_m[n] && (n % 2 == 1);
    @(posedge ref_clk);
    lag <= 2'(n % 4);
    case (src)
      0: begin
        call_vector_instruction <= 1'b1;
        call_vector_sel <= 3'(n);
      end
      1: soft_trap_instruction <= 1'b1;
      2: undefined_instruction <= 1'b1;
      3: nmi_request <= 1'b1;
      4: begin
        periph_request[n] <= 1'b1;
        dma_route_en <= (n % 2 == 1) ? '1 : '0; // odd vectors routed to dma
      end
      default: ;
    endcase
    #1;
    k = 0;
    while (vec_valid_q !== 1'b1 && dma_req_q !== 1'b1 && k < 20) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (src == 4 && !val_m[n]) begin
      chk(k, 20);
    end else if (k == 20) begin
      mismatches++;
      close_out();
    end else if (dm) begin
      chk(vec_valid_q, 0);
      chk(dma_vec_q, n);
    end else begin
      chk(dma_req_q, 0);
      chk(vec_num_q, n);
      chk(vec_offset_q, 10'h3FC - 10'(4 * n));
      chk(vec_has_icr_q, n >= 12);
      chk(icr_index_q, n >= 12 ? n : 0);
    end
    @(posedge ref_clk);
    call_vector_instruction <= 1'b0;
    soft_trap_instruction <= 1'b0;
    undefined_instruction <= 1'b0;
    nmi_request <= 1'b0;
    periph_request <= '0;
    if (dm) begin
      #1;
      k = 0;
      while (src_clear_q === '0 && k < 10) begin
        @(posedge ref_clk);
        #1;
        k++;
      end
      chk(src_clear_q, 81'h1 << n);
      if (k == 10) close_out();
    end
    repeat (12) @(posedge ref_clk);
  endtask

  // second reset in mid-run: vec_valid_q low, then the reset vector again
  task automatic reset_again();
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(vec_valid_q, 0);
    @(posedge ref_clk);
    rst <= 1'b0;
    go(8, 5);
  endtask

  // *********************************
  // main sequence
  // *********************************
  initial begin
    dma_m = '0;
    foreach (dl[j]) dma_m[dl[j]] = 1'b1;
    val_m = dma_m;
    val_m[16:12] = 5'h1F;
    val_m[35] = 1'b1;
    @(posedge ref_clk);
    #1;
    chk(vec_valid_q, 0);
    @(posedge ref_clk);
    rst <= 1'b0;
    go(8, 5);
    for (int i = 0; i < 8; i++) go(i, 0);
    go(9, 1);
    go(10, 2);
    go(11, 3);
    for (int i = 12; i < 81; i++) go(i, 4);
    reset_again();
    close_out();
  end
endmodule
